/* File: logic/pabe_pkg.sv */
// Shared constants for the port A/B/E pin function select block
package pabe_pkg;

  localparam int unsigned REG_W  = 16;
  localparam int unsigned CODE_W = 3;
  localparam int unsigned ADR_W  = 8;

  // Byte offsets on the register bus
  localparam logic [7:0] OFF_A_MODE_HI = 8'h00;
  localparam logic [7:0] OFF_A_MODE_LO = 8'h04;
  localparam logic [7:0] OFF_B_DIR     = 8'h08;
  localparam logic [7:0] OFF_B_MODE_HI = 8'h0C;
  localparam logic [7:0] OFF_B_MODE_LO = 8'h10;
  localparam logic [7:0] OFF_E_DIR_LO  = 8'h14;
  localparam logic [7:0] OFF_E_DIR_HI  = 8'h18;
  localparam logic [7:0] OFF_STATUS    = 8'h1C;

  // Writable bits; every other bit reads as zero
  localparam logic [15:0] WM_A_MODE_HI = 16'h00FF;
  localparam logic [15:0] WM_A_MODE_LO = 16'hFFFF;
  localparam logic [15:0] WM_B_DIR     = 16'h003C;
  localparam logic [15:0] WM_B_MODE_HI = 16'h3C00;
  localparam logic [15:0] WM_B_MODE_LO = 16'h0FF0;
  localparam logic [15:0] WM_E_DIR_LO  = 16'hFFFF;
  localparam logic [15:0] WM_E_DIR_HI  = 16'h003F;

  // Reset values
  localparam logic [15:0] RST_A_MODE = 16'h0000;
  localparam logic [15:0] RST_B_DIR  = 16'h0000;
  localparam logic [15:0] RST_B_MODE = 16'h0000;
  localparam logic [15:0] RST_E_DIR  = 16'h0000;

  // Field positions
  localparam int unsigned PB_FIRST_PIN = 2;
  localparam int unsigned PB_MD2_LSB   = 8;
  localparam int unsigned PE_HI_PINS   = 6;

  // Mode codes
  localparam logic [2:0] CODE_GPIO      = 3'h0;
  localparam logic [2:0] PA_CODE_TCLK   = 3'h1;
  localparam logic [2:0] PA_CODE_IRQ    = 3'h3;
  localparam logic [2:0] PA_CODE_ALT5   = 3'h5;
  localparam logic [2:0] PA_CODE_ALT6   = 3'h6;
  localparam logic [2:0] PB_CODE_IRQ    = 3'h1;
  localparam logic [2:0] PB_CODE_ODIS   = 3'h2;

  // Legal codes per pin, bit i set when code i is allowed
  localparam logic [7:0] PA_LEGAL [0:7] = '{8'h61, 8'h61, 8'h69, 8'h61,
                                            8'h61, 8'h69, 8'h23, 8'h23};
  localparam logic [7:0] PB_LEGAL = 8'h07;

endpackage

/* File: logic/pabe_ifs.sv */
// Interfaces between the pin function top and its helpers
`timescale 1ns/1ps

interface pabe_dec_if;
  logic [pabe_pkg::CODE_W-1:0] code;
  logic [7:0]                  sel;
  logic                        bad;
  modport ctl (output code, input sel, input bad);
  modport dec (input code, output sel, output bad);
endinterface

interface pabe_reg_if;
  logic                       wr;
  logic [pabe_pkg::ADR_W-1:0] adr;
  logic [pabe_pkg::REG_W-1:0] wdat;
  logic [pabe_pkg::REG_W-1:0] bmask;
  logic [pabe_pkg::REG_W-1:0] rdat;
  modport slv  (output wr, output adr, output wdat, output bmask,
                input rdat);
  modport regs (input wr, input adr, input wdat, input bmask,
                output rdat);
endinterface

/* File: logic/pabe_code_dec.sv */
// Mode code decoder: one-hot select masked by the legal codes of a pin
`timescale 1ns/1ps

module pabe_code_dec #(
  parameter logic [7:0] LEGAL = 8'h01
) (
  // Code in, selects out
  pabe_dec_if.dec d
);

  if (LEGAL[0] == 1'b0) begin : g_chk
    $error("pabe_code_dec: general-purpose code must be legal");
  end

  wire [7:0] hot;

  assign hot   = 8'h01 << d.code;
  // A prohibited code selects nothing, so the pin stays off every unit
  assign d.sel = hot & LEGAL;
  assign d.bad = ~LEGAL[d.code];

endmodule

/* File: logic/pabe_wb_slave.sv */
// Classic Wishbone slave front end, one wait state on every access
`timescale 1ns/1ps

module pabe_wb_slave #(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              nrst,
  // Wishbone
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Register side
  pabe_reg_if.slv                r
);

  if (ADDR_W < 8) begin : g_chk
    $error("pabe_wb_slave: ADDR_W must be at least 8");
  end

  logic        ack_reg;
  logic [31:0] dat_reg;
  wire         req;
  wire         hi_zero;
  wire         ack_next;
  wire  [31:0] dat_next;

  assign req      = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign hi_zero  = (wb_adr_i >> 8) == '0;
  assign r.adr    = hi_zero ? wb_adr_i[7:0] : 8'hFF;
  assign r.wr     = req & wb_we_i;
  assign r.wdat   = wb_dat_i[15:0];
  assign r.bmask  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign ack_next = req;
  assign dat_next = (req & ~wb_we_i) ? {16'h0000, r.rdat} : 32'h0000_0000;

  // Ack drops the cycle after it is given, so a request held past ack is served again every other cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

endmodule

/* File: logic/pabe_pin_function.sv */
// Pin function select for port A pins 7..0, port B pins 5..2, port E dirs
//
// Contract
// - PA7 code 000 general I/O, 001 timer clock B, 101 serial2 transmit.
// - PA6 code 000 general I/O, 001 timer clock A, 101 serial2 receive.
// - PA5 000 I/O, 011 interrupt 1, 101 disable req 6, 110 serial3 clock.
// - PA4 000 I/O, 101 disable request 5, 110 serial3 transmit.
// - PA3 000 I/O, 101 disable request 4, 110 serial3 receive.
// - PA1 000 I/O, 101 disable request 1, 110 serial2 transmit.
// - PA0 000 I/O, 101 disable request 0, 110 serial2 receive.
// - Port B direction bit one makes pin 5..2 output, zero input.
// - Port B direction only acts while that pin is general I/O.
// - Port B direction bits 15..6, 1, 0 read zero; write zero.
// - Port B and both port E direction registers reset to zero.
// - PB5 000 I/O, 001 interrupt 3, 010 disable request 3.
// - PB4 000 I/O, 001 interrupt 2, 010 disable request 2.
// - PB3 000 I/O, 001 interrupt 1, 010 disable request 1.
// - PB2 000 I/O, 001 interrupt 0, 010 disable request 0.
// - Port B mode reserved bits read zero; software writes zero.
// - Port E direction bit one makes pin 21..0 output, zero input.
// - Low port E direction acts for I/O, capture/compare, serial clocks.
// - High port E direction acts only while pins 21..16 are I/O.
// - High port E direction bits 15..6 read zero; write zero.
`timescale 1ns/1ps

module pabe_pin_function #(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              nrst,
  // Wishbone
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Port E function state from the port E control logic
  input  wire logic [15:0]       pe_low_dir_use,
  input  wire logic [5:0]        pe_high_gpio,
  // Port A function selects
  output logic      [7:0]        pa_gpio_sel,
  output logic      [1:0]        timer_ext_clock_sel,
  output logic      [1:0]        serial2_transmit_sel,
  output logic      [1:0]        serial2_receive_sel,
  output logic                   serial2_clock_pin_sel,
  output logic                   serial3_transmit_sel,
  output logic                   serial3_receive_sel,
  output logic                   serial3_clock_pin_sel,
  output logic                   motor_timer_pulse_io_sel,
  output logic      [1:0]        ext_interrupt_a_sel,
  output logic      [4:0]        output_disable_a_sel,
  // Port B function selects and direction
  output logic      [3:0]        pb_gpio_sel,
  output logic      [3:0]        ext_interrupt_b_sel,
  output logic      [3:0]        output_disable_b_sel,
  output logic      [3:0]        pb_out_en,
  // Port E direction
  output logic      [21:0]       pe_out_en,
  // Status
  output logic                   mode_fault
);

  // Merge a bus write into a register, keeping reserved bits at zero
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wdat,
                                        input logic [15:0] bmask,
                                        input logic [15:0] wmask);
    merge = ((old & ~bmask) | (wdat & bmask)) & wmask;
  endfunction

  // Assemble a 3-bit mode code from a high-bit and a low-pair register
  function automatic logic [2:0] mode_code(input logic [15:0] hi,
                                           input logic [15:0] lo,
                                           input int unsigned hpos,
                                           input int unsigned lpos);
    mode_code = {hi[hpos], lo[lpos+1], lo[lpos]};
  endfunction

  pabe_reg_if rif ();

  pabe_wb_slave #(
    .ADDR_W (ADDR_W)
  ) u_wb (
    .mclk     (mclk),
    .nrst     (nrst),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_dat_i (wb_dat_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .r        (rif)
  );

  // Registers
  logic [15:0] a_hi_reg;
  logic [15:0] a_lo_reg;
  logic [15:0] b_dir_reg;
  logic [15:0] b_hi_reg;
  logic [15:0] b_lo_reg;
  logic [15:0] e_lo_reg;
  logic [15:0] e_hi_reg;

  wire hit_a_hi;
  wire hit_a_lo;
  wire hit_b_dir;
  wire hit_b_hi;
  wire hit_b_lo;
  wire hit_e_lo;
  wire hit_e_hi;
  wire hit_stat;

  assign hit_a_hi  = rif.adr == pabe_pkg::OFF_A_MODE_HI;
  assign hit_a_lo  = rif.adr == pabe_pkg::OFF_A_MODE_LO;
  assign hit_b_dir = rif.adr == pabe_pkg::OFF_B_DIR;
  assign hit_b_hi  = rif.adr == pabe_pkg::OFF_B_MODE_HI;
  assign hit_b_lo  = rif.adr == pabe_pkg::OFF_B_MODE_LO;
  assign hit_e_lo  = rif.adr == pabe_pkg::OFF_E_DIR_LO;
  assign hit_e_hi  = rif.adr == pabe_pkg::OFF_E_DIR_HI;
  assign hit_stat  = rif.adr == pabe_pkg::OFF_STATUS;

  wire [15:0] a_hi_next;
  wire [15:0] a_lo_next;
  wire [15:0] b_dir_next;
  wire [15:0] b_hi_next;
  wire [15:0] b_lo_next;
  wire [15:0] e_lo_next;
  wire [15:0] e_hi_next;

  assign a_hi_next  = (rif.wr & hit_a_hi) ?
    merge(a_hi_reg, rif.wdat, rif.bmask, pabe_pkg::WM_A_MODE_HI) : a_hi_reg;
  assign a_lo_next  = (rif.wr & hit_a_lo) ?
    merge(a_lo_reg, rif.wdat, rif.bmask, pabe_pkg::WM_A_MODE_LO) : a_lo_reg;
  assign b_dir_next = (rif.wr & hit_b_dir) ?
    merge(b_dir_reg, rif.wdat, rif.bmask, pabe_pkg::WM_B_DIR) : b_dir_reg;
  assign b_hi_next  = (rif.wr & hit_b_hi) ?
    merge(b_hi_reg, rif.wdat, rif.bmask, pabe_pkg::WM_B_MODE_HI) : b_hi_reg;
  assign b_lo_next  = (rif.wr & hit_b_lo) ?
    merge(b_lo_reg, rif.wdat, rif.bmask, pabe_pkg::WM_B_MODE_LO) : b_lo_reg;
  assign e_lo_next  = (rif.wr & hit_e_lo) ?
    merge(e_lo_reg, rif.wdat, rif.bmask, pabe_pkg::WM_E_DIR_LO) : e_lo_reg;
  assign e_hi_next  = (rif.wr & hit_e_hi) ?
    merge(e_hi_reg, rif.wdat, rif.bmask, pabe_pkg::WM_E_DIR_HI) : e_hi_reg;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      a_hi_reg  <= pabe_pkg::RST_A_MODE;
      a_lo_reg  <= pabe_pkg::RST_A_MODE;
      b_dir_reg <= pabe_pkg::RST_B_DIR;
      b_hi_reg  <= pabe_pkg::RST_B_MODE;
      b_lo_reg  <= pabe_pkg::RST_B_MODE;
      e_lo_reg  <= pabe_pkg::RST_E_DIR;
      e_hi_reg  <= pabe_pkg::RST_E_DIR;
    end else begin
      a_hi_reg  <= a_hi_next;
      a_lo_reg  <= a_lo_next;
      b_dir_reg <= b_dir_next;
      b_hi_reg  <= b_hi_next;
      b_lo_reg  <= b_lo_next;
      e_lo_reg  <= e_lo_next;
      e_hi_reg  <= e_hi_next;
    end
  end

  // Mode decode
  pabe_dec_if pa_if [8] ();
  pabe_dec_if pb_if [4] ();
  wire [7:0] pa_sel [0:7];
  wire [7:0] pb_sel [0:3];
  wire [7:0] pa_bad;
  wire [3:0] pb_bad;

  for (genvar n = 0; n < 8; n++) begin : g_pa
    assign pa_if[n].code = mode_code(a_hi_reg, a_lo_reg, n, 2 * n);
    pabe_code_dec #(
      .LEGAL (pabe_pkg::PA_LEGAL[n])
    ) u_dec (
      .d (pa_if[n])
    );
    assign pa_sel[n] = pa_if[n].sel;
    assign pa_bad[n] = pa_if[n].bad;
  end

  for (genvar k = 0; k < 4; k++) begin : g_pb
    // Pin k+2 takes its top bit from bit 10+k, its pair from 2(k+2)
    assign pb_if[k].code = mode_code(b_hi_reg, b_lo_reg,
      pabe_pkg::PB_MD2_LSB + pabe_pkg::PB_FIRST_PIN + k,
      2 * (pabe_pkg::PB_FIRST_PIN + k));
    pabe_code_dec #(
      .LEGAL (pabe_pkg::PB_LEGAL)
    ) u_dec (
      .d (pb_if[k])
    );
    assign pb_sel[k] = pb_if[k].sel;
    assign pb_bad[k] = pb_if[k].bad;
  end

  // Read data; the status word shows which pins hold a prohibited code
  wire [15:0] status_word;
  assign status_word = {4'h0, pb_bad, pa_bad};
  assign rif.rdat = ({16{hit_a_hi}}  & a_hi_reg)
                  | ({16{hit_a_lo}}  & a_lo_reg)
                  | ({16{hit_b_dir}} & b_dir_reg)
                  | ({16{hit_b_hi}}  & b_hi_reg)
                  | ({16{hit_b_lo}}  & b_lo_reg)
                  | ({16{hit_e_lo}}  & e_lo_reg)
                  | ({16{hit_e_hi}}  & e_hi_reg)
                  | ({16{hit_stat}}  & status_word);

  // Function routing
  wire [7:0]  pa_gpio_next;
  wire [1:0]  tclk_next;
  wire [1:0]  s2_tx_next;
  wire [1:0]  s2_rx_next;
  wire [1:0]  irq_a_next;
  wire [4:0]  odis_a_next;
  wire [3:0]  pb_gpio_next;
  wire [3:0]  irq_b_next;
  wire [3:0]  odis_b_next;
  wire [3:0]  pb_oe_next;
  wire [21:0] pe_oe_next;

  for (genvar n = 0; n < 8; n++) begin : g_pa_gpio
    assign pa_gpio_next[n] = pa_sel[n][pabe_pkg::CODE_GPIO];
  end

  assign tclk_next   = {pa_sel[7][pabe_pkg::PA_CODE_TCLK],
                        pa_sel[6][pabe_pkg::PA_CODE_TCLK]};
  assign s2_tx_next  = {pa_sel[7][pabe_pkg::PA_CODE_ALT5],
                        pa_sel[1][pabe_pkg::PA_CODE_ALT6]};
  assign s2_rx_next  = {pa_sel[6][pabe_pkg::PA_CODE_ALT5],
                        pa_sel[0][pabe_pkg::PA_CODE_ALT6]};
  assign irq_a_next  = {pa_sel[5][pabe_pkg::PA_CODE_IRQ],
                        pa_sel[2][pabe_pkg::PA_CODE_IRQ]};
  assign odis_a_next = {pa_sel[5][pabe_pkg::PA_CODE_ALT5],
                        pa_sel[4][pabe_pkg::PA_CODE_ALT5],
                        pa_sel[3][pabe_pkg::PA_CODE_ALT5],
                        pa_sel[1][pabe_pkg::PA_CODE_ALT5],
                        pa_sel[0][pabe_pkg::PA_CODE_ALT5]};

  for (genvar k = 0; k < 4; k++) begin : g_pb_route
    assign pb_gpio_next[k] = pb_sel[k][pabe_pkg::CODE_GPIO];
    assign irq_b_next[k]   = pb_sel[k][pabe_pkg::PB_CODE_IRQ];
    assign odis_b_next[k]  = pb_sel[k][pabe_pkg::PB_CODE_ODIS];
  end

  // Port B and high port E direction is forced to input outside general I/O, low port E outside pe_low_dir_use
  assign pb_oe_next = b_dir_reg[5:2] & pb_gpio_next;
  assign pe_oe_next = {e_hi_reg[5:0] & pe_high_gpio,
                       e_lo_reg & pe_low_dir_use};

  // Output flops; every select lags its register write by one cycle
  logic [7:0]  pa_gpio_reg;
  logic [1:0]  tclk_reg;
  logic [1:0]  s2_tx_reg;
  logic [1:0]  s2_rx_reg;
  logic        s2_ck_reg;
  logic        s3_tx_reg;
  logic        s3_rx_reg;
  logic        s3_ck_reg;
  logic        motor_reg;
  logic [1:0]  irq_a_reg;
  logic [4:0]  odis_a_reg;
  logic [3:0]  pb_gpio_reg;
  logic [3:0]  irq_b_reg;
  logic [3:0]  odis_b_reg;
  logic [3:0]  pb_oe_reg;
  logic [21:0] pe_oe_reg;
  logic        fault_reg;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pa_gpio_reg <= 8'hFF;
      tclk_reg    <= 2'h0;
      s2_tx_reg   <= 2'h0;
      s2_rx_reg   <= 2'h0;
      s2_ck_reg   <= 1'b0;
      s3_tx_reg   <= 1'b0;
      s3_rx_reg   <= 1'b0;
      s3_ck_reg   <= 1'b0;
      motor_reg   <= 1'b0;
      irq_a_reg   <= 2'h0;
      odis_a_reg  <= 5'h00;
      pb_gpio_reg <= 4'hF;
      irq_b_reg   <= 4'h0;
      odis_b_reg  <= 4'h0;
      pb_oe_reg   <= 4'h0;
      pe_oe_reg   <= 22'h00_0000;
      fault_reg   <= 1'b0;
    end else begin
      pa_gpio_reg <= pa_gpio_next;
      tclk_reg    <= tclk_next;
      s2_tx_reg   <= s2_tx_next;
      s2_rx_reg   <= s2_rx_next;
      s2_ck_reg   <= pa_sel[2][pabe_pkg::PA_CODE_ALT6];
      s3_tx_reg   <= pa_sel[4][pabe_pkg::PA_CODE_ALT6];
      s3_rx_reg   <= pa_sel[3][pabe_pkg::PA_CODE_ALT6];
      s3_ck_reg   <= pa_sel[5][pabe_pkg::PA_CODE_ALT6];
      motor_reg   <= pa_sel[2][pabe_pkg::PA_CODE_ALT5];
      irq_a_reg   <= irq_a_next;
      odis_a_reg  <= odis_a_next;
      pb_gpio_reg <= pb_gpio_next;
      irq_b_reg   <= irq_b_next;
      odis_b_reg  <= odis_b_next;
      pb_oe_reg   <= pb_oe_next;
      pe_oe_reg   <= pe_oe_next;
      fault_reg   <= |{pa_bad, pb_bad};
    end
  end

  assign pa_gpio_sel              = pa_gpio_reg;
  assign timer_ext_clock_sel      = tclk_reg;
  assign serial2_transmit_sel     = s2_tx_reg;
  assign serial2_receive_sel      = s2_rx_reg;
  assign serial2_clock_pin_sel    = s2_ck_reg;
  assign serial3_transmit_sel     = s3_tx_reg;
  assign serial3_receive_sel      = s3_rx_reg;
  assign serial3_clock_pin_sel    = s3_ck_reg;
  assign motor_timer_pulse_io_sel = motor_reg;
  assign ext_interrupt_a_sel      = irq_a_reg;
  assign output_disable_a_sel     = odis_a_reg;
  assign pb_gpio_sel              = pb_gpio_reg;
  assign ext_interrupt_b_sel      = irq_b_reg;
  assign output_disable_b_sel     = odis_b_reg;
  assign pb_out_en                = pb_oe_reg;
  assign pe_out_en                = pe_oe_reg;
  assign mode_fault               = fault_reg;

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  property p_pa7_route;
    (pa_if[7].code == 3'h1) |=> (timer_ext_clock_sel[1]
      && !serial2_transmit_sel[1] && !pa_gpio_sel[7]);
  endproperty
  a_pa7_route: assert property (p_pa7_route)
    else $error("PA7 code 001 did not select timer clock B");

  property p_pa6_route;
    (pa_if[6].code == 3'h5) |=> (serial2_receive_sel[1]
      && !timer_ext_clock_sel[0]);
  endproperty
  a_pa6_route: assert property (p_pa6_route)
    else $error("PA6 code 101 did not select serial2 receive");

  property p_pa5_route;
    (pa_if[5].code == 3'h3) |=> (ext_interrupt_a_sel[1]
      && !output_disable_a_sel[4] && !serial3_clock_pin_sel);
  endproperty
  a_pa5_route: assert property (p_pa5_route)
    else $error("PA5 code 011 did not select interrupt 1");

  property p_pa2_route;
    (pa_if[2].code == 3'h5) |=> (motor_timer_pulse_io_sel
      && !serial2_clock_pin_sel && !ext_interrupt_a_sel[0]);
  endproperty
  a_pa2_route: assert property (p_pa2_route)
    else $error("PA2 code 101 did not select motor pulse pin");

  property p_pa_prohibited;
    (pa_if[4].code == 3'h2) |=> (mode_fault && !pa_gpio_sel[4]
      && !serial3_transmit_sel && !output_disable_a_sel[3]);
  endproperty
  a_pa_prohibited: assert property (p_pa_prohibited)
    else $error("PA4 prohibited code was not isolated");

  property p_pb_dir;
    pb_out_en == $past(b_dir_reg[5:2] & {pb_if[3].code == 3'h0,
      pb_if[2].code == 3'h0, pb_if[1].code == 3'h0,
      pb_if[0].code == 3'h0});
  endproperty
  a_pb_dir: assert property (p_pb_dir)
    else $error("Port B output enable ignores mode or direction");

  property p_pb5_route;
    (pb_if[3].code == 3'h2) |=> (output_disable_b_sel[3]
      && !ext_interrupt_b_sel[3] && !pb_out_en[3]);
  endproperty
  a_pb5_route: assert property (p_pb5_route)
    else $error("PB5 code 010 did not select disable request 3");

  property p_pb_read_zero;
    (wb_ack_o && !wb_we_i && wb_adr_i == ADDR_W'(pabe_pkg::OFF_B_DIR))
      |-> (wb_dat_o[15:6] == 10'h000 && wb_dat_o[1:0] == 2'h0);
  endproperty
  a_pb_read_zero: assert property (p_pb_read_zero)
    else $error("Port B direction reserved bits read nonzero");

  property p_reset_dirs;
    $rose(nrst) |-> (b_dir_reg == 16'h0000 && e_lo_reg == 16'h0000
      && e_hi_reg == 16'h0000);
  endproperty
  a_reset_dirs: assert property (p_reset_dirs)
    else $error("Direction registers not zero after reset");

  property p_pe_dir;
    pe_out_en == $past({e_hi_reg[5:0] & pe_high_gpio,
      e_lo_reg & pe_low_dir_use});
  endproperty
  a_pe_dir: assert property (p_pe_dir)
    else $error("Port E output enable ignores pin function");

  sequence s_write_e_hi;
    rif.wr && hit_e_hi && rif.bmask[15:8] == 8'hFF
      && rif.wdat[15:8] == 8'hFF;
  endsequence
  sequence s_e_hi_clean;
    (e_hi_reg[15:6] == 10'h000) [*2];
  endsequence
  property p_e_hi_reserved;
    s_write_e_hi |=> s_e_hi_clean;
  endproperty
  a_e_hi_reserved: assert property (p_e_hi_reserved)
    else $error("Port E high direction reserved bits were stored");

endmodule

/* File: dv/pabe_pin_function_bench.sv */
// Self-checking bench for the port A/B/E pin function select block
`timescale 1ns/1ps
module pabe_pin_function_bench;
  // Pin*8+code that raises each port A select bit, bit 0 upward
  localparam logic [5:0] KEY [0:17] = '{6'h05, 6'h0D, 6'h1D, 6'h25,
    6'h2D, 6'h13, 6'h2B, 6'h15, 6'h2E, 6'h1E, 6'h26, 6'h16, 6'h06,
    6'h35, 6'h0E, 6'h3D, 6'h31, 6'h39};
  logic        mclk, nrst, cyc, stb, we, ack, flt;
  logic [7:0]  adr, pag;
  logic [31:0] dw, dr, rd;
  logic [15:0] pel;
  logic [5:0]  peh;
  logic [3:0]  pbg, pbi, pbo, pbe, eg;
  logic [17:0] pas, ea;
  logic [21:0] pee;
  int          n_fail = 0;
  int          checks = 0;
  pabe_pin_function i_pabe_pin_function (.mclk(mclk), .nrst(nrst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(dw), .wb_sel_i(4'h3), .wb_dat_o(dr), .wb_ack_o(ack),
    .pe_low_dir_use(pel), .pe_high_gpio(peh), .pa_gpio_sel(pag),
    .timer_ext_clock_sel(pas[17:16]), .serial2_transmit_sel(pas[15:14]),
    .serial2_receive_sel(pas[13:12]), .serial2_clock_pin_sel(pas[11]),
    .serial3_transmit_sel(pas[10]), .serial3_receive_sel(pas[9]),
    .serial3_clock_pin_sel(pas[8]), .motor_timer_pulse_io_sel(pas[7]),
    .ext_interrupt_a_sel(pas[6:5]), .output_disable_a_sel(pas[4:0]),
    .pb_gpio_sel(pbg), .ext_interrupt_b_sel(pbi),
    .output_disable_b_sel(pbo), .pb_out_en(pbe), .pe_out_en(pee),
    .mode_fault(flt));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk(string nm, logic [63:0] s, logic [63:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One classic cycle; the slave's wait states are not assumed
  task automatic wb(logic w, logic [7:0] a, logic [15:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dw  <= {16'h0000, d};
    for (int n = 0; n < 50 && ack !== 1'b1; n++) @(posedge mclk);
    chk("ack", ack, 1);
    rd = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    n_fail++;
    wrap_up;
  end
  initial begin
    {nrst, cyc, stb, we, adr, dw} = '0;
    pel = 16'hFFFF;
    peh = 6'h3F;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      wb(1'b0, 8'(4 * i), 16'h0000);
      chk("reset", rd, 0);
    end
    chk("reset_out", {pas, pag, pbg, pbi, pbo, pbe},
        {18'h0, 8'hFF, 4'hF, 12'h0});
    chk("reset_pe", {pee, flt}, 23'h0);
    $display("test reset done");
    for (int p = 0; p < 8; p++) begin
      for (int c = 0; c < 8; c++) begin
        wb(1'b1, pabe_pkg::OFF_A_MODE_HI, 16'(c / 4) << p);
        wb(1'b1, pabe_pkg::OFF_A_MODE_LO, 16'(c % 4) << (2 * p));
        ea = '0;
        for (int b = 0; b < 18; b++) begin
          if (KEY[b] == 6'(p * 8 + c)) ea[b] = 1'b1;
        end
        @(negedge mclk);
        chk("pa_sel", pas, ea);
        chk("pa_gpio", pag, 8'hFF ^ (8'(c != 0) << p));
        chk("pa_fault", flt, c != 0 && ea == '0);
      end
    end
    // Leave port A legal so the port B fault checks see only port B
    wb(1'b1, pabe_pkg::OFF_A_MODE_HI, 16'h0000);
    wb(1'b1, pabe_pkg::OFF_A_MODE_LO, 16'h0000);
    $display("test port a done");
    wb(1'b1, pabe_pkg::OFF_B_DIR, 16'hFFFF);
    wb(1'b0, pabe_pkg::OFF_B_DIR, 16'h0000);
    chk("pb_dir_rd", rd, 16'h003C);
    for (int k = 0; k < 4; k++) begin
      for (int c = 0; c < 8; c++) begin
        wb(1'b1, pabe_pkg::OFF_B_MODE_HI, 16'(c / 4) << (10 + k));
        wb(1'b1, pabe_pkg::OFF_B_MODE_LO, 16'(c % 4) << (4 + 2 * k));
        eg = 4'hF ^ (4'(c != 0) << k);
        @(negedge mclk);
        chk("pb_sel", {pbg, pbi, pbo},
            {eg, 4'(c == 1) << k, 4'(c == 2) << k});
        chk("pb_oe", pbe, eg);
        chk("pb_fault", flt, c > 2);
      end
    end
    wb(1'b1, pabe_pkg::OFF_B_MODE_HI, 16'hFFFF);
    wb(1'b1, pabe_pkg::OFF_B_MODE_LO, 16'hFFFF);
    wb(1'b0, pabe_pkg::OFF_B_MODE_HI, 16'h0000);
    chk("pb_md_hi", rd, 16'h3C00);
    wb(1'b0, pabe_pkg::OFF_B_MODE_LO, 16'h0000);
    chk("pb_md_lo", rd, 16'h0FF0);
    $display("test port b done");
    wb(1'b1, pabe_pkg::OFF_E_DIR_LO, 16'hFFFF);
    wb(1'b1, pabe_pkg::OFF_E_DIR_HI, 16'hFFFF);
    wb(1'b0, pabe_pkg::OFF_E_DIR_HI, 16'h0000);
    chk("pe_hi_rd", rd, 16'h003F);
    @(negedge mclk);
    chk("pe_oe_all", pee, 22'h3FFFFF);
    @(posedge mclk);
    pel <= 16'hA5A5;
    peh <= 6'h2A;
    wb(1'b1, pabe_pkg::OFF_E_DIR_LO, 16'h00FF);
    @(negedge mclk);
    chk("pe_oe_use", pee, {6'h2A, 16'h00A5});
    wb(1'b0, 8'h40, 16'h0000);
    chk("unmapped", rd, 0);
    wb(1'b0, pabe_pkg::OFF_STATUS, 16'h0000);
    chk("status", rd, 16'h0F00);
    $display("test port e done");
    wrap_up;
  end
endmodule
